// *** pkg/eeprom_host_pkg.sv ***
// package: constants, types and timing for the paged eeprom host controller
package eeprom_host_pkg;
  localparam int CLK_HZ = 100_000_000;
  localparam int ADDR_W = 15;
  localparam int DATA_W = 8;
  localparam int PAGE_LSB = 6;
  localparam int PAGE_BYTES = 64;
  // timing figures as printed
  localparam int BYTE_LOAD_WINDOW_US = 150;
  localparam int INTERNAL_PROGRAM_TIME_MS = 10;
  localparam int ERASE_SETUP_TIME_US = 5;
  localparam int ERASE_HOLD_TIME_US = 5;
  localparam int ERASE_PULSE_TIME_MS = 10;
  // cycle counts; the per-unit clock factor truncates, so every time rounds down
  localparam int BYTE_LOAD_WINDOW_CYC = BYTE_LOAD_WINDOW_US * (CLK_HZ / 1_000_000);
  localparam int ERASE_SETUP_CYC = ERASE_SETUP_TIME_US * (CLK_HZ / 1_000_000);
  localparam int ERASE_HOLD_CYC = ERASE_HOLD_TIME_US * (CLK_HZ / 1_000_000);
  localparam int ERASE_PULSE_CYC = ERASE_PULSE_TIME_MS * (CLK_HZ / 1_000);
  localparam int INTERNAL_PROGRAM_CYC = INTERNAL_PROGRAM_TIME_MS * (CLK_HZ / 1_000);
  // strobe phase lengths in cycles (setup, low pulse, high recovery)
  localparam int STROBE_SETUP_CYC = 2;
  localparam int STROBE_LOW_CYC = 12;
  localparam int STROBE_HIGH_CYC = 6;
  localparam int READ_ACCESS_CYC = 16;
  // guard command sequences (three writes to enable, six to disable), enable and disable tails
  localparam logic [14:0] GUARD_ADDR_A = 15'h5555;
  localparam logic [14:0] GUARD_ADDR_B = 15'h2aaa;
  localparam logic [7:0] GUARD_DATA_A = 8'haa;
  localparam logic [7:0] GUARD_DATA_B = 8'h55;
  localparam logic [7:0] GUARD_DATA_ON = 8'ha0;
  localparam logic [7:0] GUARD_DATA_OFF1 = 8'h80;
  localparam logic [7:0] GUARD_DATA_OFF2 = 8'h20;
  localparam logic [7:0] GUARD_DATA_OFF0 = 8'haa;

  typedef enum logic [2:0] {
    CMD_READ,
    CMD_PAGE_WRITE,
    CMD_GUARD_ON,
    CMD_GUARD_OFF,
    CMD_ERASE
  } cmd_t;

  typedef struct packed {
    cmd_t cmd;
    logic [14:0] addr;
    logic [6:0] count;
    logic guarded;
  } request_t;

  typedef struct packed {
    logic ce_n;
    logic oe_n;
    logic we_n;
    logic oe_high_level;
    logic [14:0] addr;
  } pins_t;

  typedef struct packed {
    logic [7:0] data;
    logic timeout;
  } answer_t;
endpackage : eeprom_host_pkg

// *** core/page_buffer.sv ***
// page buffer: 64 bytes of write data, registered read
`timescale 1ns/1ns
`default_nettype none
module page_buffer #(
  parameter int DEPTH = 64,
  parameter int WIDTH = 8
) (
  input wire logic clk,
  input wire logic wr_en,
  input wire logic [$clog2(DEPTH)-1:0] wr_addr,
  input wire logic [WIDTH-1:0] wr_data,
  input wire logic [$clog2(DEPTH)-1:0] rd_addr,
  output logic [WIDTH-1:0] rd_data
);
  logic [WIDTH-1:0] mem [DEPTH];

  initial begin
    if (DEPTH < 2) $error("page_buffer depth too small");
  end

  always_ff @(posedge clk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
  end

  always_ff @(posedge clk) begin
    rd_data <= mem[rd_addr];
  end
endmodule : page_buffer
`default_nettype wire

// *** core/eeprom_host.sv ***
// host controller driving a paged parallel eeprom through its pins
// Contract
// - page address A6-A14 stays unchanged at each data-byte strobe fall of a load; guard bytes go to GUARD_ADDR_A and GUARD_ADDR_B.
// - output enable stays high while write strobe and chip enable are low.
// - each further byte starts within 150 us of the previous one.
// - after a guard sequence, one to sixty-four data bytes are loaded; a CMD_GUARD_ON request with count 0 loads none.
// - after the unlock bytes, the page address stays fixed at each strobe fall.
// - command bytes go on the data lines, command addresses on the address lines.
// - erase: chip enable low, high-level oe, write low 10 ms, 5 us around.
// - with guard active, every write is preceded by the three-byte sequence; the host sends it only for CMD_GUARD_ON or a page write that sets guarded.
`timescale 1ns/1ns
`default_nettype none
module eeprom_host
  import eeprom_host_pkg::*;
#(
  parameter int ERASE_PULSE = ERASE_PULSE_CYC,
  parameter int PROGRAM_TIMEOUT = 2 * INTERNAL_PROGRAM_CYC,
  parameter int LOAD_WINDOW = BYTE_LOAD_WINDOW_CYC
) (
  input wire logic CLK_SYS,
  input wire logic RST,
  input wire logic REQ_VALID,
  output logic REQ_READY,
  input wire eeprom_host_pkg::request_t REQ,
  input wire logic WDATA_VALID,
  input wire logic [7:0] WDATA,
  output logic WDATA_READY,
  output logic ANS_VALID,
  output eeprom_host_pkg::answer_t ANS,
  output eeprom_host_pkg::pins_t PINS,
  output logic [7:0] DQ_O,
  output logic DQ_OE,
  input wire logic [7:0] DQ_I
);
  import eeprom_host_pkg::*;

  initial begin
    if (LOAD_WINDOW <= STROBE_SETUP_CYC + STROBE_LOW_CYC + STROBE_HIGH_CYC + 3) $error("eeprom_host window too small");
    if (ERASE_PULSE < 1 || PROGRAM_TIMEOUT < 4) $error("eeprom_host timing too small");
  end

  typedef enum {
    S_IDLE, S_LOAD, S_SET, S_LOW, S_HIGH, S_ERASE_SU, S_ERASE_P, S_ERASE_H,
    S_POLL_SET, S_POLL_LOW, S_POLL_HIGH, S_DONE
  } state_t;

  ////////////////////////////////////////////////////////////////////////
  state_t state_q;
  request_t req_q;
  logic [6:0] loaded_q;
  logic [2:0] pre_q;
  logic [31:0] cnt_q;
  logic [31:0] wait_q;
  logic [7:0] dq_s1_q;
  logic [7:0] dq_s2_q;
  logic [7:0] last_data_q;
  logic [7:0] cur_data_q;
  logic [14:0] cur_addr_q;
  logic poll_first_q;
  logic bit6_q;
  logic timeout_q;
  logic ce_n_q;
  logic oe_n_q;
  logic we_n_q;
  logic hv_q;
  logic dq_oe_q;
  logic [7:0] buf_rd;
  logic buf_wr;
  logic phase_done;

  // two stages on the data pins: they change outside this clock's domain
  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      dq_s1_q <= 8'h00;
      dq_s2_q <= 8'h00;
    end else begin
      dq_s1_q <= DQ_I;
      dq_s2_q <= dq_s1_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // buffered load decouples the byte source from the 150 us window
  assign buf_wr = (state_q == S_LOAD) && WDATA_VALID && (loaded_q < req_q.count);
  assign WDATA_READY = (state_q == S_LOAD) && (loaded_q < req_q.count);
  assign REQ_READY = (state_q == S_IDLE);
  assign phase_done = (cnt_q == 32'h0);

  page_buffer #(.DEPTH(PAGE_BYTES), .WIDTH(DATA_W)) u_buf (
    .clk(CLK_SYS),
    .wr_en(buf_wr),
    .wr_addr(loaded_q[5:0]),
    .wr_data(WDATA),
    .rd_addr(loaded_q[5:0]),
    .rd_data(buf_rd)
  );

  function automatic logic [22:0] cmd_byte(input cmd_t c, input logic [2:0] i);
    logic [22:0] r;
    r = {GUARD_ADDR_A, GUARD_DATA_A};
    case (i)
      3'h0: r = {GUARD_ADDR_A, GUARD_DATA_A};
      3'h1: r = {GUARD_ADDR_B, GUARD_DATA_B};
      3'h2: r = {GUARD_ADDR_A, (c == CMD_GUARD_OFF) ? GUARD_DATA_OFF1 : GUARD_DATA_ON};
      3'h3: r = {GUARD_ADDR_A, GUARD_DATA_OFF0};
      3'h4: r = {GUARD_ADDR_B, GUARD_DATA_B};
      default: r = {GUARD_ADDR_A, GUARD_DATA_OFF2};
    endcase
    return r;
  endfunction

  function automatic logic [2:0] cmd_len(input request_t r);
    logic [2:0] n;
    n = 3'h0;
    if (r.cmd == CMD_GUARD_OFF) n = 3'h6;
    else if (r.cmd == CMD_GUARD_ON || (r.cmd == CMD_PAGE_WRITE && r.guarded)) n = 3'h3;
    return n;
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // main sequencer
  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      state_q <= S_IDLE;
      req_q <= '0;
      loaded_q <= 7'h00;
      pre_q <= 3'h0;
      cnt_q <= 32'h0;
      wait_q <= 32'h0;
      cur_data_q <= 8'h00;
      cur_addr_q <= 15'h0000;
      last_data_q <= 8'h00;
      poll_first_q <= 1'b0;
      bit6_q <= 1'b0;
      timeout_q <= 1'b0;
    end else begin
      if (!phase_done) cnt_q <= cnt_q - 32'h1;
      case (state_q)
        S_IDLE: begin
          timeout_q <= 1'b0;
          if (REQ_VALID) begin
            req_q <= REQ;
            loaded_q <= 7'h00;
            pre_q <= 3'h0;
            cur_addr_q <= REQ.addr;
            if (REQ.cmd == CMD_ERASE) begin
              state_q <= S_ERASE_SU;
              cnt_q <= 32'(ERASE_SETUP_CYC);
            end else if (REQ.cmd == CMD_READ) begin
              state_q <= S_SET;
              cnt_q <= 32'(STROBE_SETUP_CYC);
            end else begin
              state_q <= S_LOAD;
            end
          end
        end
        S_LOAD: begin
          // all bytes buffered first so strobes come back to back
          if (buf_wr) loaded_q <= loaded_q + 7'h01;
          if (loaded_q == req_q.count || (buf_wr && loaded_q + 7'h01 == req_q.count)) begin
            loaded_q <= 7'h00;
            state_q <= S_SET;
            cnt_q <= 32'(STROBE_SETUP_CYC);
            if (cmd_len(req_q) != 3'h0) {cur_addr_q, cur_data_q} <= cmd_byte(req_q.cmd, 3'h0);
          end
        end
        S_SET: begin
          if (req_q.cmd != CMD_READ && pre_q >= cmd_len(req_q)) begin
            cur_data_q <= buf_rd;
          end
          if (phase_done) begin
            state_q <= S_LOW;
            cnt_q <= 32'(req_q.cmd == CMD_READ ? READ_ACCESS_CYC : STROBE_LOW_CYC);
          end
        end
        S_LOW: begin
          if (phase_done) begin
            state_q <= S_HIGH;
            cnt_q <= 32'(STROBE_HIGH_CYC);
            if (req_q.cmd == CMD_READ) cur_data_q <= dq_s2_q;
          end
        end
        S_HIGH: begin
          if (phase_done) begin
            if (req_q.cmd == CMD_READ) begin
              state_q <= S_DONE;
            end else if (pre_q + 3'h1 < cmd_len(req_q) || (pre_q < cmd_len(req_q) && req_q.count != 7'h00)) begin
              pre_q <= pre_q + 3'h1;
              state_q <= S_SET;
              cnt_q <= 32'(STROBE_SETUP_CYC);
              if (pre_q + 3'h1 < cmd_len(req_q)) begin
                {cur_addr_q, cur_data_q} <= cmd_byte(req_q.cmd, pre_q + 3'h1);
              end else begin
                cur_addr_q <= req_q.addr;
              end
            end else if (loaded_q + 7'h01 < req_q.count) begin
              loaded_q <= loaded_q + 7'h01;
              cur_addr_q <= {req_q.addr[14:6], cur_addr_q[5:0] + 6'h01};
              state_q <= S_SET;
              cnt_q <= 32'(STROBE_SETUP_CYC);
            end else begin
              last_data_q <= cur_data_q;
              poll_first_q <= 1'b1;
              wait_q <= 32'h0;
              state_q <= S_POLL_SET;
              cnt_q <= 32'(STROBE_SETUP_CYC);
            end
          end
        end
        S_ERASE_SU: if (phase_done) begin
          state_q <= S_ERASE_P;
          cnt_q <= 32'(ERASE_PULSE);
        end
        S_ERASE_P: if (phase_done) begin
          state_q <= S_ERASE_H;
          cnt_q <= 32'(ERASE_HOLD_CYC);
        end
        S_ERASE_H: if (phase_done) state_q <= S_DONE;
        S_POLL_SET: begin
          wait_q <= wait_q + 32'h1;
          if (phase_done) begin
            state_q <= S_POLL_LOW;
            cnt_q <= 32'(READ_ACCESS_CYC);
          end
        end
        S_POLL_LOW: begin
          wait_q <= wait_q + 32'h1;
          if (phase_done) begin
            state_q <= S_POLL_HIGH;
            cnt_q <= 32'(STROBE_HIGH_CYC);
            poll_first_q <= 1'b0;
            bit6_q <= dq_s2_q[6];
            cur_data_q <= dq_s2_q;
            // done when bit 6 stopped toggling and bit 7 matches the last byte written; command-only loads wrote no byte
            if (!poll_first_q && dq_s2_q[6] == bit6_q &&
                (dq_s2_q[7] == last_data_q[7] || req_q.count == 7'h00)) begin
              state_q <= S_DONE;
            end else if (wait_q > 32'(PROGRAM_TIMEOUT)) begin
              timeout_q <= 1'b1;
              state_q <= S_DONE;
            end
          end
        end
        S_POLL_HIGH: begin
          wait_q <= wait_q + 32'h1;
          if (phase_done) begin
            state_q <= S_POLL_SET;
            cnt_q <= 32'(STROBE_SETUP_CYC);
          end
        end
        S_DONE: state_q <= S_IDLE;
        default: state_q <= S_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // pin drive; oe stays high through every write strobe
  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      ce_n_q <= 1'b1;
      oe_n_q <= 1'b1;
      we_n_q <= 1'b1;
      hv_q <= 1'b0;
      dq_oe_q <= 1'b0;
    end else begin
      ce_n_q <= !(state_q inside {S_LOW, S_POLL_LOW, S_ERASE_SU, S_ERASE_P, S_ERASE_H});
      oe_n_q <= !((state_q == S_LOW && req_q.cmd == CMD_READ) || state_q == S_POLL_LOW);
      we_n_q <= !((state_q == S_LOW && req_q.cmd != CMD_READ) || state_q == S_ERASE_P);
      hv_q <= state_q inside {S_ERASE_SU, S_ERASE_P, S_ERASE_H};
      dq_oe_q <= (req_q.cmd != CMD_READ) && (state_q inside {S_SET, S_LOW, S_HIGH});
    end
  end

  // the strobe low time (130 ns) is far below the 150 us load window
  assign PINS.ce_n = ce_n_q;
  assign PINS.oe_n = oe_n_q | hv_q;
  assign PINS.we_n = we_n_q;
  assign PINS.oe_high_level = hv_q;
  assign PINS.addr = cur_addr_q;
  assign DQ_O = cur_data_q;
  assign DQ_OE = dq_oe_q;
  assign ANS_VALID = (state_q == S_DONE);
  assign ANS.data = cur_data_q;
  assign ANS.timeout = timeout_q;
endmodule : eeprom_host
`default_nettype wire

// *** testbench/eeprom_host_asserts.sv ***
// checker: pin-level rules of the eeprom host controller
`timescale 1ns/1ns
`default_nettype none
module eeprom_host_asserts
  import eeprom_host_pkg::*;
#(
  parameter int ERASE_PULSE = 200,
  parameter int LOAD_WINDOW = 100
) (
  input wire logic CLK_SYS,
  input wire logic RST,
  input wire logic REQ_READY,
  input wire eeprom_host_pkg::pins_t PINS,
  input wire logic [7:0] DQ_O,
  input wire logic DQ_OE
);
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (RST);
  int lo_q;
  int gap_q;
  logic load_q;
  // a read clears load_q, so the gap is only judged inside one load
  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      lo_q <= 0;
      gap_q <= 0;
      load_q <= 1'b0;
    end else begin
      lo_q <= (!PINS.we_n && PINS.oe_high_level) ? lo_q + 1 : 0;
      gap_q <= $fell(PINS.we_n) ? 0 : gap_q + 1;
      load_q <= $fell(PINS.we_n) ? 1'b1 : (load_q && PINS.oe_n);
    end
  end
  //////////////////////////////////////////
  a_oe_write_high: assert property (!PINS.we_n && !PINS.ce_n |-> PINS.oe_n)
    else $error("oe low during write");
  a_no_contention: assert property (!PINS.ce_n && !PINS.oe_n && PINS.we_n |-> !DQ_OE)
    else $error("host drives data during read");
  a_write_inhibit: assert property (!PINS.oe_n |-> PINS.we_n)
    else $error("write strobe with oe low");
  a_erase_level: assert property (PINS.oe_high_level |-> PINS.oe_n && !PINS.ce_n)
    else $error("oe not high at erase level");
  a_erase_pulse: assert property ($rose(PINS.we_n) && PINS.oe_high_level |-> lo_q >= ERASE_PULSE)
    else $error("erase pulse short");
  a_erase_setup: assert property ($rose(PINS.oe_high_level) |=> PINS.we_n [*8])
    else $error("erase setup short");
  a_erase_hold: assert property ($fell(PINS.oe_high_level) |-> $past(PINS.we_n, 8))
    else $error("erase hold short");
  a_strobe_hold: assert property (!PINS.we_n && !PINS.oe_high_level |-> DQ_OE && $stable(PINS.addr) && $stable(DQ_O))
    else $error("address or data moved in strobe");
  a_byte_window: assert property ($fell(PINS.we_n) && load_q |-> gap_q < LOAD_WINDOW)
    else $error("byte load gap too long");
  a_idle_standby: assert property (REQ_READY |-> PINS.ce_n && PINS.we_n)
    else $error("idle without standby");
  c_erase: cover property ($rose(PINS.oe_high_level));
  c_page_byte: cover property ($fell(PINS.we_n) && load_q);
  c_read: cover property ($fell(PINS.oe_n));
endmodule : eeprom_host_asserts
bind eeprom_host eeprom_host_asserts #(.ERASE_PULSE(ERASE_PULSE), .LOAD_WINDOW(LOAD_WINDOW)) chk_u (
  .CLK_SYS(CLK_SYS), .RST(RST), .REQ_READY(REQ_READY), .PINS(PINS), .DQ_O(DQ_O), .DQ_OE(DQ_OE));
`default_nettype wire

// *** testbench/eeprom_model.sv ***
// device model: paged eeprom behind the host pins
`timescale 1ns/1ns
`default_nettype none
module eeprom_model
  import eeprom_host_pkg::*;
#(
  parameter int EP = 200
) (
  input wire logic clk,
  input wire eeprom_host_pkg::pins_t pins,
  input wire logic [7:0] dq,
  output logic [7:0] q
);
  logic [7:0] mem [0:32767];
  logic [22:0] st_q [$];
  logic [7:0] last_q, wv_q, lw_q;
  logic [14:0] wa_q;
  logic low_q, tog_q, g_q, gn_q, oe_q, pend_q;
  int ld, busy, ec;
  initial begin
    foreach (mem[i]) mem[i] = 8'hff;
    {low_q, tog_q, g_q, gn_q, oe_q, pend_q, last_q, lw_q} = '0;
    {ld, busy, ec} = '0;
  end
  // a floating bus shows the inverse of its last level, never a kind value
  assign q = (!pins.ce_n && !pins.oe_n && pins.we_n) ?
    (busy > 0 || pend_q ? {~lw_q[7], tog_q, lw_q[5:0]} : mem[pins.addr]) : ~last_q;
  task automatic commit();
    int s;
    s = 0;
    gn_q = g_q;
    if (st_q.size() >= 3 && st_q[0] == {GUARD_ADDR_A, GUARD_DATA_A} && st_q[1] == {GUARD_ADDR_B, GUARD_DATA_B}) begin
      if (st_q[2] == {GUARD_ADDR_A, GUARD_DATA_ON}) begin s = 3; gn_q = 1'b1; end
      else if (st_q.size() >= 6 && st_q[2] == {GUARD_ADDR_A, GUARD_DATA_OFF1}) begin s = 6; gn_q = 1'b0; end
    end
    if (s > 0 || !g_q) for (int i = s; i < st_q.size(); i++) mem[st_q[i][22:8]] = st_q[i][7:0];
    st_q.delete();
  endtask : commit
  always @(posedge clk) begin
    last_q <= dq;
    oe_q <= pins.oe_n;
    if ((busy > 0 || pend_q) && oe_q && !pins.oe_n && !pins.ce_n) tog_q <= ~tog_q;
    if (!pins.ce_n && !pins.we_n && pins.oe_n && !pins.oe_high_level && busy == 0) begin
      if (!low_q) wa_q <= pins.addr;
      wv_q <= dq;
      low_q <= 1'b1;
    end else if (low_q) begin
      st_q.push_back({wa_q, wv_q});
      low_q <= 1'b0;
      // reads inside the load period already poll, since the host polls at once
      lw_q <= wv_q;
      pend_q <= 1'b1;
      ld = 0;
    end else if (st_q.size() > 0 && ++ld > 150) begin
      commit();
      pend_q <= 1'b0;
      busy = 400;
    end
    if (busy > 0 && --busy == 0) g_q <= gn_q;
    if (!pins.ce_n && pins.oe_high_level && !pins.we_n) ec++;
    else begin
      if (ec >= EP) foreach (mem[i]) mem[i] = 8'hff;
      ec = 0;
    end
  end
endmodule : eeprom_model
`default_nettype wire

// *** testbench/test_eeprom_host.sv ***
// testbench: host controller against device model and reference memory
`timescale 1ns/1ns
`default_nettype none
module test_eeprom_host;
  import eeprom_host_pkg::*;
  logic CLK_SYS = 0, RST = 1, REQ_VALID = 0, WDATA_VALID = 0, ref_g = 0;
  logic REQ_READY, WDATA_READY, ANS_VALID, DQ_OE;
  logic [7:0] WDATA = '0, DQ_O, dev_q;
  logic [7:0] ref_m [0:32767];
  logic [7:0] buf_q [64];
  logic [31:0] rs = 15207;
  request_t REQ = '0;
  answer_t ANS, ans_q;
  pins_t PINS;
  int err_total = 0, check_count = 0, cyc = 0;
  wire logic [7:0] dq_w = DQ_OE ? DQ_O : dev_q;
  always #5 CLK_SYS = ~CLK_SYS;
  eeprom_host #(.ERASE_PULSE(200), .PROGRAM_TIMEOUT(2000), .LOAD_WINDOW(100)) dut_u (.CLK_SYS(CLK_SYS),
    .RST(RST), .REQ_VALID(REQ_VALID), .REQ_READY(REQ_READY), .REQ(REQ), .WDATA_VALID(WDATA_VALID),
    .WDATA(WDATA), .WDATA_READY(WDATA_READY), .ANS_VALID(ANS_VALID), .ANS(ANS), .PINS(PINS),
    .DQ_O(DQ_O), .DQ_OE(DQ_OE), .DQ_I(dq_w));
  eeprom_model #(.EP(200)) dev_u (.clk(CLK_SYS), .pins(PINS), .dq(dq_w), .q(dev_q));
  //////////////////////////////////////////
  function automatic logic [7:0] rnd();
    rs ^= rs << 13;
    rs ^= rs >> 17;
    rs ^= rs << 5;
    return rs[7:0];
  endfunction : rnd
  task automatic chk_data(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp) begin
      err_total++;
      $display("CHECK FAILED t=%0t data got %h exp %h", $time, got, exp);
    end
  endtask : chk_data
  task automatic chk_to(input logic got, input logic exp);
    check_count++;
    if (got !== exp) begin
      err_total++;
      $display("CHECK FAILED t=%0t timeout got %h exp %h", $time, got, exp);
    end
  endtask : chk_to
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : wrap_up
  task automatic do_req(input cmd_t c, input logic [14:0] a, input int n, input logic g);
    int k;
    @(negedge CLK_SYS);
    REQ = '{c, a, 7'(n), g};
    REQ_VALID = 1'b1;
    while (REQ_READY !== 1'b1) @(negedge CLK_SYS);
    @(negedge CLK_SYS);
    REQ_VALID = 1'b0;
    for (k = 0; k < n; k++) begin
      WDATA = buf_q[k];
      WDATA_VALID = 1'b1;
      while (WDATA_READY !== 1'b1) @(negedge CLK_SYS);
      @(negedge CLK_SYS);
    end
    WDATA_VALID = 1'b0;
    for (k = 0; k < 5000 && ANS_VALID !== 1'b1; k++) @(negedge CLK_SYS);
    if (k == 5000) chk_to(1'b1, 1'b0);
    ans_q = ANS;
  endtask : do_req
  // a blocked write keeps bit 7 of the old byte so polling can still settle
  task automatic run(input cmd_t c, input logic [14:0] a, input int n, input logic g);
    logic [14:0] ad;
    logic [7:0] v;
    for (int i = 0; i < n; i++) begin
      ad = {a[14:6], 6'(a[5:0] + i)};
      v = rnd();
      buf_q[i] = v;
      if (!g && ref_g) buf_q[i][7] = ref_m[ad][7];
      else ref_m[ad] = v;
    end
    do_req(c, a, n, g);
    chk_to(ans_q.timeout, 1'b0);
    if (c == CMD_ERASE) foreach (ref_m[k]) ref_m[k] = 8'hff;
    if (c == CMD_GUARD_ON || c == CMD_GUARD_OFF) ref_g = (c == CMD_GUARD_ON);
    if (n > 0) chk_data(ans_q.data, ref_m[ad]);
    for (int i = 0; i < (n > 0 ? n : 4); i++) begin
      ad = {a[14:6], 6'(a[5:0] + i)};
      do_req(CMD_READ, ad, 0, 1'b0);
      chk_data(ans_q.data, ref_m[ad]);
    end
    $display("test %s done", c.name());
  endtask : run
  always @(posedge CLK_SYS) if (++cyc == 60000) begin
    chk_to(1'b1, 1'b0);
    wrap_up();
  end
  initial begin
    foreach (ref_m[k]) ref_m[k] = 8'hff;
    repeat (12) @(posedge CLK_SYS);
    @(negedge CLK_SYS);
    RST = 1'b0;
    run(CMD_PAGE_WRITE, 15'h01ff, 64, 1'b0);
    run(CMD_PAGE_WRITE, 15'h0413, 1, 1'b0);
    run(CMD_GUARD_ON, 15'h0000, 0, 1'b0);
    run(CMD_PAGE_WRITE, 15'h01c5, 2, 1'b0);
    run(CMD_PAGE_WRITE, 15'h01c5, 3, 1'b1);
    run(CMD_GUARD_OFF, 15'h0000, 0, 1'b0);
    run(CMD_PAGE_WRITE, 15'h01c5, 2, 1'b0);
    run(CMD_ERASE, 15'h01c0, 0, 1'b0);
    wrap_up();
  end
endmodule : test_eeprom_host
`default_nettype wire
